// File: rtl/afe_spi_pkg.sv
// shared constants, field layout and types of the serial register interface
package afe_spi_pkg;
  localparam int          REG_W      = 24;
  localparam int          IDX_W      = 5;
  localparam int          N_REGS     = 32;
  localparam int          FRAME_MAX  = 32;
  // register indices
  localparam logic [4:0]  IDX_LAST_ADC = 5'h07;
  localparam logic [4:0]  IDX_FIRST_WR = 5'h08;
  localparam logic [4:0]  IDX_MOD      = 5'h08;
  localparam logic [4:0]  IDX_COMM     = 5'h0C;
  localparam logic [4:0]  IDX_LOCK     = 5'h1F;
  // comm_status_reg field positions
  localparam int          RD_LOOP_HI  = 23;
  localparam int          RD_LOOP_LO  = 22;
  localparam int          WR_LOOP_BIT = 21;
  localparam int          WIDTH_HI    = 20;
  localparam int          WIDTH_LO    = 19;
  localparam int          CRC_RD_BIT  = 18;
  localparam int          CRC_IRQ_BIT = 17;
  // lock/checksum register: key byte on top, checksum in the low 16 bits
  localparam int          LOCK_HI     = 23;
  localparam int          LOCK_LO     = 16;
  localparam logic [23:0] LOCK_MASK   = 24'hFF0000;
  localparam logic [7:0]  LOCK_KEY    = 8'hA5;
  // reset values
  localparam logic [23:0] COMM_RESET  = 24'hA80000;
  localparam logic [23:0] LOCK_RESET  = 24'hA50000;
  localparam logic [23:0] ZERO_RESET  = 24'h000000;
  // loop and width encodings
  localparam logic [1:0]  LOOP_STATIC = 2'h0;
  localparam logic [1:0]  LOOP_GROUPS = 2'h1;
  localparam logic [1:0]  LOOP_TYPES  = 2'h2;
  localparam logic [1:0]  LOOP_FULL   = 2'h3;
  localparam logic [1:0]  WIDTH_16    = 2'h0;
  localparam logic [1:0]  WIDTH_24    = 2'h1;
  localparam logic [5:0]  LEN_CMD     = 6'h08;
  localparam logic [5:0]  LEN_16      = 6'h10;
  localparam logic [5:0]  LEN_24      = 6'h18;
  localparam logic [5:0]  LEN_32      = 6'h20;
  localparam logic [15:0] CRC_POLY    = 16'h8005;
  localparam logic [15:0] CRC_SEED    = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD, ST_READ, ST_WRITE, ST_SKIP
  } spiState_t;

  typedef struct packed {
    logic [4:0]  idx;
    logic [23:0] data;
  } wrReq_t;
endpackage

// File: rtl/afe_two_entry_buf.sv
// small ring buffer with valid/ready on both sides
`timescale 1ns/1ps
module afe_two_entry_buf #(
  parameter int W     = 29,
  parameter int DEPTH = 2
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  localparam int PW = $clog2(DEPTH) + 1;
  logic [W-1:0]  store_r [DEPTH];
  logic [PW-1:0] count_r;
  logic [PW-2:0] head_r;
  logic [PW-2:0] tail_r;
  logic          push;
  logic          pop;

  // honest full/empty straight from the fill count
  assign inReady  = (count_r != PW'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData  = store_r[head_r];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // pointers and fill count
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_r <= '0;
      head_r  <= '0;
      tail_r  <= '0;
    end else begin
      if (push) begin
        tail_r <= (tail_r == (PW-1)'(DEPTH-1)) ? '0 : tail_r + 1'b1;
      end
      if (pop) begin
        head_r <= (head_r == (PW-1)'(DEPTH-1)) ? '0 : head_r + 1'b1;
      end
      count_r <= count_r + PW'(push) - PW'(pop);
    end
  end

  // storage needs no reset, contents are qualified by the count
  always_ff @(posedge clk) begin
    if (push) begin
      store_r[tail_r] <= inData;
    end
  end
endmodule

// File: rtl/afe_reg_file.sv
// register map storage with two registered read ports and one write port
`timescale 1ns/1ps
module afe_reg_file (
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  input  wire logic                   wrValid,
  output logic                        wrReady,
  input  wire afe_spi_pkg::wrReq_t    wrReq,
  input  wire logic [4:0]             rdIdxA,
  output logic [23:0]                 rdDataA,
  input  wire logic [4:0]             rdIdxB,
  output logic [23:0]                 rdDataB,
  output logic [23:0]                 commReg,
  output logic [7:0]                  lockKey
);
  logic [23:0] mem_r [afe_spi_pkg::N_REGS];

  function automatic logic [23:0] resetVal(input int i);
    if (i == int'(afe_spi_pkg::IDX_COMM)) begin
      return afe_spi_pkg::COMM_RESET;
    end else if (i == int'(afe_spi_pkg::IDX_LOCK)) begin
      return afe_spi_pkg::LOCK_RESET;
    end
    return afe_spi_pkg::ZERO_RESET;
  endfunction

  // hold off a write to the word the checksum walker is reading, so a
  // word is not written in the same clock it is read; the write lands one clock later
  assign wrReady = !(wrValid && (wrReq.idx == rdIdxB));
  assign commReg = mem_r[afe_spi_pkg::IDX_COMM];
  assign lockKey =
    mem_r[afe_spi_pkg::IDX_LOCK][afe_spi_pkg::LOCK_HI:afe_spi_pkg::LOCK_LO];

  // storage, restored to power-up values by the master reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < afe_spi_pkg::N_REGS; i++) begin
        mem_r[i] <= resetVal(i);
      end
    end else if (wrValid && wrReady) begin
      if (wrReq.idx == afe_spi_pkg::IDX_LOCK) begin
        mem_r[wrReq.idx] <= wrReq.data & afe_spi_pkg::LOCK_MASK;
      end else begin
        mem_r[wrReq.idx] <= wrReq.data;
      end
    end
  end

  // registered read ports
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdDataA <= '0;
      rdDataB <= '0;
    end else begin
      rdDataA <= mem_r[rdIdxA];
      rdDataB <= mem_r[rdIdxB];
    end
  end
endmodule

// File: rtl/afe_spi_regif.sv
// serial register interface slave of the front end, with lock and checksums
`timescale 1ns/1ps
// Notes on behaviour
// - works in clock modes 0,0 and 1,1; clock idles low or high
// - output changes on falling clock edges, input captured on rising edges
// - serial pins are asynchronous; every crossing is synchronised
// - select falling starts a transaction; select rising aborts and resets
// - select high: output tri-stated, clock and data ignored
// - master reset pin restores every power-up default
// - command byte: two chip bits, five index bits, direction bit lowest
// - index picks one of thirty-two whole registers
// - output stays tri-stated throughout the command byte
// - act only when the chip bits match our identifier, default 01
// - register frames are 16, 24 or 32 bits, chosen by format field
// - reads continue past the first register while select stays low
// - two-bit read-loop field chooses one of four address advances
// - writes continue, index advanced or held by the write-loop bit
// - output stays tri-stated during any write transaction
// - writes to read-only or undefined indices change nothing, hold address
// - writes other than to the lock register are refused unless the lock key holds A5
// - background checksum over writable registers except modulator output
// - checksum change with interrupt enabled pulls sample-ready low
// - optional checksum appended after each read sequence
// - auto address wraps to the set's first location at its end
// - read loop 00 static, 01 groups, 10 types, 11 full map
// - serial input after the command byte is ignored during reads
// - with the key not A5 only the lock register stays writable
module afe_spi_regif #(
  parameter logic [1:0] CHIP_ID = 2'h1
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        csPin_n,
  input  wire logic        sckPin,
  input  wire logic        sdiPin,
  output logic             sdo,
  output logic             sdoOe,
  output logic             sample_ready_n,
  output logic [15:0]      configCrc
);
  import afe_spi_pkg::*;
  // ==========================================================
  // helpers
  function automatic logic [15:0] crcBit(input logic [15:0] c,
                                         input logic b);
    return {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC_POLY : 16'h0000);
  endfunction

  function automatic logic [5:0] frameLen(input logic [1:0] w);
    return (w == WIDTH_16) ? LEN_16 : (w == WIDTH_24) ? LEN_24 : LEN_32;
  endfunction

  function automatic logic [4:0] nextAddr(input logic [4:0] a,
                                          input logic [1:0] m);
    case (m)
      LOOP_STATIC: return a;
      LOOP_GROUPS: return {a[4:1], ~a[0]};
      LOOP_TYPES:  return (a == IDX_LAST_ADC) ? 5'h00 :
                          (a == IDX_LOCK) ? IDX_FIRST_WR : 5'(a + 5'h01);
      default:     return 5'(a + 5'h01);
    endcase
  endfunction

  function automatic logic setEnd(input logic [4:0] a, input logic [1:0] m);
    case (m)
      LOOP_STATIC: return 1'b1;
      LOOP_GROUPS: return a[0];
      LOOP_TYPES:  return (a == IDX_LAST_ADC) || (a == IDX_LOCK);
      default:     return a == IDX_LOCK;
    endcase
  endfunction

  // ==========================================================
  // pin synchronisers and edge detection
  logic [2:0]  csSync_r;
  logic [2:0]  sckSync_r;
  logic [1:0]  sdiSync_r;
  // stage 0 feeds stage 1 only; edges compare stages 1 and 2
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      csSync_r  <= 3'h7;
      sckSync_r <= 3'h0;
      sdiSync_r <= 2'h0;
    end else begin
      csSync_r  <= {csSync_r[1:0], csPin_n};
      sckSync_r <= {sckSync_r[1:0], sckPin};
      sdiSync_r <= {sdiSync_r[0], sdiPin};
    end
  end
  logic csHigh;
  logic csRise;
  logic csFall;
  logic sckRise;
  logic sckFall;
  logic sdiBit;
  assign csHigh  = csSync_r[1];
  assign csRise  = csSync_r[1] && !csSync_r[2];
  assign csFall  = !csSync_r[1] && csSync_r[2];
  // either idle level works: only edges count
  assign sckRise = sckSync_r[1] && !sckSync_r[2] && !csHigh;
  assign sckFall = !sckSync_r[1] && sckSync_r[2] && !csHigh;
  assign sdiBit  = sdiSync_r[1];

  // ==========================================================
  // register map, write buffer and configuration fields
  logic [23:0] rdDataA;
  logic [23:0] rdDataB;
  logic [23:0] commReg;
  logic [7:0]  lockKey;
  logic [4:0]  crcIdx_r;
  logic        bufInValid;
  logic        bufInReady;
  wrReq_t      bufIn;
  logic        memWrValid;
  logic        memWrReady;
  wrReq_t      memWrReq;
  logic [4:0]  addr_r;

  afe_two_entry_buf #(.W($bits(wrReq_t)), .DEPTH(2)) afe_two_entry_buf_i (
    .clk      (clk),
    .arst_n   (arst_n),
    .inValid  (bufInValid),
    .inReady  (bufInReady),
    .inData   (bufIn),
    .outValid (memWrValid),
    .outReady (memWrReady),
    .outData  (memWrReq)
  );

  afe_reg_file afe_reg_file_i (
    .clk     (clk),
    .arst_n  (arst_n),
    .wrValid (memWrValid),
    .wrReady (memWrReady),
    .wrReq   (memWrReq),
    .rdIdxA  (addr_r),
    .rdDataA (rdDataA),
    .rdIdxB  (crcIdx_r),
    .rdDataB (rdDataB),
    .commReg (commReg),
    .lockKey (lockKey)
  );

  logic [1:0] rdLoop;
  logic [1:0] wrLoop;
  logic [1:0] width;
  logic [5:0] dataLen;
  assign rdLoop  = commReg[RD_LOOP_HI:RD_LOOP_LO];
  assign wrLoop  = commReg[WR_LOOP_BIT] ? LOOP_TYPES : LOOP_STATIC;
  assign width   = commReg[WIDTH_HI:WIDTH_LO];
  assign dataLen = frameLen(width);

  // ==========================================================
  // transaction sequencer
  spiState_t   state_r;
  logic [5:0]  bitCnt_r;
  logic [31:0] rxShift_r;
  logic [31:0] rxWord;
  logic [7:0]  cmdByte;
  logic        lastBit;
  logic        canWrite;
  logic        sendCrc_r;
  logic        crcNext_r;
  logic        loadPend_r;
  assign rxWord  = {rxShift_r[30:0], sdiBit}; // msb arrives first
  assign cmdByte = rxWord[7:0];
  assign lastBit = (bitCnt_r == ((state_r == ST_CMD) ? LEN_CMD :
                    sendCrc_r ? LEN_16 : dataLen) - 6'h01);
  // only configuration indices, and only the key once locked
  assign canWrite = (addr_r >= IDX_FIRST_WR) &&
                    ((lockKey == LOCK_KEY) || (addr_r == IDX_LOCK));
  // a frame is stored only once complete; cut frames never reach here
  assign bufInValid = (state_r == ST_WRITE) && sckRise && lastBit &&
                      canWrite;
  assign bufIn.idx  = addr_r;
  assign bufIn.data = (width == WIDTH_16) ? {rxWord[15:0], 8'h00} :
                      (width == WIDTH_24) ? rxWord[23:0] : rxWord[31:8];

  // state, bit count and address pointer; select rising wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r    <= ST_IDLE;
      bitCnt_r   <= '0;
      rxShift_r  <= '0;
      addr_r     <= '0;
      sendCrc_r  <= 1'b0;
      crcNext_r  <= 1'b0;
      loadPend_r <= 1'b0;
    end else if (csRise || csHigh) begin
      state_r    <= ST_IDLE;
      sendCrc_r  <= 1'b0;
      crcNext_r  <= 1'b0;
      loadPend_r <= 1'b0;
    end else if (csFall) begin
      state_r  <= ST_CMD;
      bitCnt_r <= '0;
    end else if (sckRise) begin
      bitCnt_r  <= lastBit ? 6'h00 : 6'(bitCnt_r + 6'h01);
      rxShift_r <= rxWord;
      case (state_r)
        ST_CMD: begin
          if (lastBit) begin
            if (cmdByte[7:6] != CHIP_ID) begin
              state_r <= ST_SKIP;
            end else begin
              addr_r     <= cmdByte[5:1];
              state_r    <= cmdByte[0] ? ST_READ : ST_WRITE;
              loadPend_r <= cmdByte[0];
            end
          end
        end
        ST_READ: begin
          // input bits are shifted but never used here
          if (lastBit) begin
            loadPend_r <= 1'b1;
            if (sendCrc_r) begin
              sendCrc_r <= 1'b0;
            end else begin
              crcNext_r <= commReg[CRC_RD_BIT] && setEnd(addr_r, rdLoop);
              addr_r    <= nextAddr(addr_r, rdLoop);
            end
          end
        end
        ST_WRITE: begin
          // refused writes keep the pointer where it is
          if (lastBit && canWrite) begin
            addr_r <= nextAddr(addr_r, wrLoop);
          end
        end
        default: begin
        end
      endcase
    end else if (sckFall && loadPend_r) begin
      loadPend_r <= 1'b0;
      sendCrc_r  <= crcNext_r;
      crcNext_r  <= 1'b0;
    end
  end

  // ==========================================================
  // serial output path: loaded and shifted on falling edges only
  logic [31:0] txShift_r;
  logic [15:0] txCrc_r;
  logic [23:0] rdWord;
  logic [31:0] txWord;
  logic        readsLock;
  assign readsLock = (addr_r == IDX_LOCK);
  assign rdWord = readsLock ? {lockKey, configCrc} : rdDataA;
  // the checksum frame goes out ahead of the next register when it is due
  assign txWord = crcNext_r ? {txCrc_r, 16'h0000} :
                  (width == WIDTH_16) ? {rdWord[23:8], 16'h0000} :
                  (width == WIDTH_24) ? {rdWord, 8'h00} : {rdWord, 8'h00};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txShift_r <= '0;
      txCrc_r   <= CRC_SEED;
      sdo       <= 1'b0;
      sdoOe     <= 1'b0;
    end else if (csRise || csHigh || state_r != ST_READ) begin
      sdoOe   <= 1'b0;
      txCrc_r <= CRC_SEED;
    end else if (sckFall) begin
      sdoOe <= 1'b1;
      if (loadPend_r) begin
        txShift_r <= txWord;
        sdo       <= txWord[31];
        txCrc_r   <= crcNext_r ? CRC_SEED : crcBit(txCrc_r, txWord[31]);
      end else begin
        txShift_r <= {txShift_r[30:0], 1'b0};
        sdo       <= txShift_r[30];
        txCrc_r   <= sendCrc_r ? txCrc_r : crcBit(txCrc_r, txShift_r[30]);
      end
    end
  end

  // ==========================================================
  // background configuration checksum, one word per clock
  logic [4:0]  crcIdxD_r;
  logic [15:0] crcRun_r;
  logic        crcPassed_r;
  logic        crcFlag_r;
  logic [15:0] crcWord;
  logic        crcTake;
  logic        flagSet;
  logic        flagClr;
  always_comb begin
    crcWord = crcRun_r;
    for (int i = REG_W - 1; i >= 0; i--) begin
      crcWord = crcBit(crcWord, rdDataB[i]);
    end
  end
  assign crcTake = (crcIdxD_r >= IDX_FIRST_WR) && (crcIdxD_r != IDX_MOD);
  assign flagSet = (crcIdxD_r == IDX_LOCK) && crcPassed_r &&
                   (crcWord != configCrc) && commReg[CRC_IRQ_BIT];
  // reading the checksum acknowledges the alert
  assign flagClr = (state_r == ST_READ) && sckFall && loadPend_r &&
                   readsLock && !crcNext_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      crcIdx_r    <= '0;
      crcIdxD_r   <= '0;
      crcRun_r    <= CRC_SEED;
      configCrc   <= CRC_SEED;
      crcPassed_r <= 1'b0;
    end else begin
      crcIdx_r  <= 5'(crcIdx_r + 5'h01);
      crcIdxD_r <= crcIdx_r;
      if (crcIdxD_r == IDX_LOCK) begin
        configCrc   <= crcWord;
        crcRun_r    <= CRC_SEED;
        crcPassed_r <= 1'b1;
      end else if (crcTake) begin
        crcRun_r <= crcWord;
      end
    end
  end

  // alert flag: a new event wins over a same-cycle acknowledge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      crcFlag_r      <= 1'b0;
      sample_ready_n <= 1'b1;
    end else begin
      crcFlag_r      <= flagSet || (crcFlag_r && !flagClr);
      sample_ready_n <= !crcFlag_r;
    end
  end

  // ==========================================================
  // assertions and covers
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_abort_idle:  assert property (csRise |=> state_r == ST_IDLE)
    else $error("select rise did not abort");
  chk_oe_deselect: assert property (csHigh |=> !sdoOe)
    else $error("output driven while deselected");
  chk_oe_command:  assert property (state_r == ST_CMD |=> !sdoOe)
    else $error("output driven in command byte");
  chk_oe_write:    assert property (state_r == ST_WRITE |=> !sdoOe)
    else $error("output driven during write");
  chk_sdo_fall:    assert property ($changed(sdo) |-> $past(sckFall))
    else $error("output moved without falling edge");
  chk_wr_lock:     assert property (bufInValid |->
                     lockKey == LOCK_KEY || bufIn.idx == IDX_LOCK)
    else $error("write passed a closed lock");
  chk_wr_ro:       assert property (bufInValid |->
                     bufIn.idx >= IDX_FIRST_WR)
    else $error("write to read-only index");
  chk_chip_id:     assert property (state_r == ST_CMD && sckRise && lastBit &&
                     cmdByte[7:6] != CHIP_ID && !csRise && !csHigh
                     |=> state_r == ST_SKIP)
    else $error("foreign chip address accepted");
  chk_alert_pin:   assert property (flagSet |=> ##1 !sample_ready_n)
    else $error("alert did not reach the pin");

  cov_read:  cover property (state_r == ST_READ && loadPend_r && sckFall);
  cov_write: cover property (bufInValid);
  cov_crc:   cover property (sendCrc_r && sckFall);
  cov_alert: cover property (flagSet);
endmodule

// File: tb/afe_spi_host.sv
// host serial master model driving the register interface pins
`timescale 1ns/1ps
module afe_spi_host (
  input  wire logic clk,
  input  wire logic sdo,
  input  wire logic sdoOe,
  output logic      csPin_n,
  output logic      sckPin,
  output logic      sdiPin
);
  logic lastSdo;
  logic sdoLine;
  // ==========================================================
  // released line
  // no pull on the line: show the inverse of the last driven level
  always @(posedge clk) if (sdoOe) lastSdo <= sdo;
  assign sdoLine = sdoOe ? sdo : ~lastSdo;
  initial begin
    csPin_n = 1'b1;
    sckPin  = 1'b0;
    sdiPin  = 1'b0;
    lastSdo = 1'b0;
  end
  // ==========================================================
  // transaction
  // command then nb bits of wd, left aligned; rd gathers sdo at each rise
  task automatic xfer(input logic m, input logic [7:0] cmd, input int nb,
                      input logic [63:0] wd, output logic [63:0] rd);
    logic [71:0] sh;
    sh = {cmd, wd};
    rd = '0;
    @(posedge clk);
    #0.3 sckPin <= m;
    #32 csPin_n <= 1'b0;
    for (int i = 0; i < 8 + nb; i++) begin
      if (m) #32 sckPin <= 1'b0;
      sdiPin <= sh[71-i];
      #32 rd = {rd[62:0], sdoLine};
      sckPin <= 1'b1;
      if (!m) #32 sckPin <= 1'b0;
    end
    #32 csPin_n <= 1'b1;
    sdiPin <= ~sdiPin;
    #64;
  endtask
endmodule

// File: tb/afe_spi_regif_bench.sv
// self-checking bench of the serial register interface
`timescale 1ns/1ps
module afe_spi_regif_bench;
  typedef struct packed {
    logic [4:0]  idx;
    logic        doWr;
    logic [23:0] wd;
    logic [23:0] exp;
  } row_t;
  logic        clk    = 1'b0;
  logic        arst_n = 1'b0;
  logic        csPin_n;
  logic        sckPin;
  logic        sdiPin;
  logic        sdo;
  logic        sdoOe;
  logic        sample_ready_n;
  logic [15:0] configCrc;
  logic        oeSeen = 1'b0;
  logic [63:0] rd;
  logic [15:0] crc0;
  int          nFail  = 0;
  int          nTests = 0;
  row_t        rows [5];

  afe_spi_regif afe_spi_regif_i (
    .clk(clk), .arst_n(arst_n), .csPin_n(csPin_n), .sckPin(sckPin),
    .sdiPin(sdiPin), .sdo(sdo), .sdoOe(sdoOe),
    .sample_ready_n(sample_ready_n), .configCrc(configCrc));
  afe_spi_host afe_spi_host_i (
    .clk(clk), .sdo(sdo), .sdoOe(sdoOe), .csPin_n(csPin_n),
    .sckPin(sckPin), .sdiPin(sdiPin));

  always #2.5 clk = ~clk;
  // any enable at all between clears is remembered
  always @(posedge clk) if (sdoOe === 1'b1) oeSeen <= 1'b1;

  // ==========================================================
  // tasks
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    nTests++;
    if (seen !== exp) begin
      nFail++;
      $display("unexpected at %0t ns: saw %h, want %h", $time, seen, exp);
    end
  endtask
  // reference checksum of one 24-bit frame, msb first
  function automatic logic [15:0] crc24(input logic [23:0] d);
    logic [15:0] c;
    c = afe_spi_pkg::CRC_SEED;
    for (int i = 23; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^
          ((c[15] ^ d[i]) ? afe_spi_pkg::CRC_POLY : 16'h0000);
    end
    return c;
  endfunction
  task automatic endOfTest();
    if (nFail == 0 && nTests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // mode 0 access of our own chip id
  task automatic acc(input logic [4:0] idx, input logic r, input int nb,
                     input logic [63:0] wd);
    afe_spi_host_i.xfer(1'b0, {2'h1, idx, r}, nb, wd, rd);
  endtask
  task automatic wr24(input logic [4:0] idx, input logic [23:0] d);
    acc(idx, 1'b0, 24, {d, 40'h0});
  endtask
  // read sends all ones on sdi, which must not matter
  task automatic rd24(input logic [4:0] idx);
    acc(idx, 1'b1, 24, '1);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    rows = '{'{5'h09, 1'b1, 24'h123456, 24'h123456},
             '{5'h0A, 1'b1, 24'hABCDEF, 24'hABCDEF},
             '{5'h1E, 1'b1, 24'h00FF00, 24'h00FF00},
             '{5'h03, 1'b1, 24'h777777, 24'h000000},
             '{5'h00, 1'b0, 24'h000000, 24'h000000}};
    repeat (8) @(posedge clk);
    check({sdoOe, sample_ready_n, configCrc}, {2'b01, 16'h0});
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    foreach (rows[k]) begin
      oeSeen = 1'b0;
      if (rows[k].doWr) wr24(rows[k].idx, rows[k].wd);
      check(oeSeen, 1'b0);
      rd24(rows[k].idx);
      check(rd[23:0], rows[k].exp);
    end
    // other chip ids: nothing stored, output never enabled
    oeSeen = 1'b0;
    afe_spi_host_i.xfer(1'b0, {7'h09, 1'b0}, 24, {24'h1, 40'h0}, rd);
    afe_spi_host_i.xfer(1'b0, {7'h49, 1'b1}, 24, '1, rd);
    check(oeSeen, 1'b0);
    rd24(5'h09);
    check(rd[23:0], 24'h123456);
    // types loop wraps from the lock register back to 0x08
    acc(5'h1F, 1'b1, 48, '1);
    check({rd[47:40], rd[23:0]}, {8'hA5, 24'h0});
    acc(5'h09, 1'b0, 48, {48'h111111222222, 16'h0});
    acc(5'h09, 1'b1, 48, '1);
    check(rd[47:0], 48'h111111222222);
    afe_spi_host_i.xfer(1'b1, {2'h1, 5'h09, 1'b1}, 24, '1, rd);
    check(rd[23:0], 24'h111111);
    // frame cut short by select rising is dropped
    acc(5'h09, 1'b0, 12, {24'h999999, 40'h0});
    rd24(5'h09);
    check(rd[23:0], 24'h111111);
    // cleared key refuses writes; the key itself stays writable
    wr24(5'h1F, 24'h0);
    wr24(5'h09, 24'h333333);
    rd24(5'h09);
    check(rd[23:0], 24'h111111);
    wr24(5'h1F, 24'hA50000);
    wr24(5'h09, 24'h444444);
    rd24(5'h09);
    check(rd[23:0], 24'h444444);
    // checksum alert on a settings change, cleared by reading the key
    crc0 = configCrc;
    wr24(5'h0C, 24'hAA0000);
    wr24(5'h0A, 24'h555555);
    for (int i = 0; i < 200 && sample_ready_n !== 1'b0; i++) @(posedge clk);
    #1 check(sample_ready_n, 1'b0);
    check(configCrc !== crc0, 1'b1);
    rd24(5'h1F);
    #1 check(sample_ready_n, 1'b1);
    // remaining read-loop codes: static, pairs, full map
    wr24(5'h0C, 24'h280000);
    acc(5'h09, 1'b1, 48, '1);
    check(rd[47:0], 48'h444444444444);
    wr24(5'h0C, 24'h680000);
    acc(5'h09, 1'b1, 48, '1);
    check(rd[47:0], 48'h444444000000);
    wr24(5'h0C, 24'hE80000);
    acc(5'h1F, 1'b1, 48, '1);
    check({rd[47:40], rd[23:0]}, {8'hA5, 24'h0});
    // static write loop, and a checksum after every read frame
    wr24(5'h0C, 24'h0C0000);
    acc(5'h0A, 1'b0, 48, {48'h777777888888, 16'h0});
    acc(5'h0A, 1'b1, 40, '1);
    check(rd[39:0], {24'h888888, crc24(24'h888888)});
    // 16-bit and 32-bit frames
    wr24(5'h0C, 24'hA00000);
    acc(5'h09, 1'b1, 16, '1);
    check(rd[15:0], 16'h4444);
    acc(5'h0C, 1'b0, 16, {16'hB000, 48'h0});
    acc(5'h09, 1'b0, 32, {32'h66666600, 32'h0});
    acc(5'h09, 1'b1, 32, '1);
    check(rd[31:0], 32'h66666600);
    // reset in mid-run brings back every power-up value
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    check({sdoOe, sample_ready_n, configCrc}, {2'b01, 16'h0});
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd24(5'h09);
    check(rd[23:0], 24'h0);
    rd24(5'h0C);
    check(rd[23:0], 24'hA80000);
    endOfTest();
  end

  // watchdog: the sequence needs about a quarter of this span
  initial begin
    #400000;
    nFail++;
    $display("unexpected at %0t ns: run timed out", $time);
    endOfTest();
  end
endmodule
